// >>> rtl/od_classifier.sv
// per-sample orientation classifier
`timescale 1ns/100ps
module od_classifier (
	input wire logic clock,
	input wire logic nrst,
	input wire logic signed [11:0] accX,
	input wire logic signed [11:0] accY,
	input wire logic signed [11:0] accZ,
	input wire logic sampleValid,
	input wire logic [1:0] tripSel,
	input wire logic [2:0] lockSel,
	input wire logic curFacing,
	output logic candFacing,
	output logic [1:0] candCode,
	output logic candLock,
	output logic candValid
);
	// ---------------------------------------------------------------
	// magnitudes and thresholds
	// ---------------------------------------------------------------
	function automatic logic [11:0] magnitude(input logic signed [11:0] v);
		magnitude = v[11] ? 12'(-v) : 12'(v);
	endfunction : magnitude

	logic [11:0] magX, magY, magZ, facingTrip, lockTrip;
	logic overRange, facing_d, lock_d, valid_d, facing_q, lock_q, valid_q;
	logic [1:0] code_d, code_q;

	// trip levels from the two select fields
	always_comb begin
		magX = magnitude(accX);
		magY = magnitude(accY);
		magZ = magnitude(accZ);
		case (tripSel)
			2'h0: facingTrip = od_pkg::FACING_TRIP_80;
			2'h1: facingTrip = od_pkg::FACING_TRIP_75;
			2'h2: facingTrip = od_pkg::FACING_TRIP_70;
			default: facingTrip = od_pkg::FACING_TRIP_65;
		endcase
		case (lockSel)
			3'h0: lockTrip = od_pkg::LOCK_14;
			3'h1: lockTrip = od_pkg::LOCK_18;
			3'h2: lockTrip = od_pkg::LOCK_21;
			3'h3: lockTrip = od_pkg::LOCK_25;
			3'h4: lockTrip = od_pkg::LOCK_29;
			3'h5: lockTrip = od_pkg::LOCK_33;
			3'h6: lockTrip = od_pkg::LOCK_37;
			default: lockTrip = od_pkg::LOCK_42;
		endcase
	end

	// classify; the band between the two facing bounds keeps the last facing
	always_comb begin
		overRange = (magX > od_pkg::OVER_RANGE_LIMIT) || (magY > od_pkg::OVER_RANGE_LIMIT)
			|| (magZ > od_pkg::OVER_RANGE_LIMIT);
		facing_d = facing_q;
		lock_d = lock_q;
		code_d = code_q;
		valid_d = 1'b0;
		if (sampleValid && !overRange) begin
			valid_d = 1'b1;
			if (!accZ[11] && magZ > facingTrip)
				facing_d = 1'b1;
			else if (accZ[11] && magZ > facingTrip)
				facing_d = 1'b0;
			else
				facing_d = curFacing;
			lock_d = magZ > lockTrip;
			if (magY >= magX)
				code_d = accY[11] ? od_pkg::CODE_PORTRAIT_DOWN : od_pkg::CODE_PORTRAIT_UP;
			else
				code_d = accX[11] ? od_pkg::CODE_LANDSCAPE_LEFT : od_pkg::CODE_LANDSCAPE_RIGHT;
		end else if (!sampleValid) begin
			valid_d = valid_q; // keep the last valid verdict between samples
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			facing_q <= 1'b0;
			lock_q <= 1'b0;
			code_q <= 2'h0;
			valid_q <= 1'b0;
		end else begin
			facing_q <= facing_d;
			lock_q <= lock_d;
			code_q <= code_d;
			valid_q <= valid_d;
		end
	end

	assign candFacing = facing_q;
	assign candCode = code_q;
	assign candLock = lock_q;
	assign candValid = valid_q;

	chk_overrange_holds: assert property (@(posedge clock) disable iff (!nrst)
		(sampleValid && overRange) |=> !candValid && $stable(candCode) && $stable(candFacing))
		else $error("over-range sample changed the candidate");
endmodule : od_classifier

// >>> rtl/od_detector.sv
// orientation detector: registers, time step, debounce and change flag
// Functional notes
// - change flag on first result and any change
// - status read clears change flag unless a new change sets it in the read cycle
// - status read drops the interrupt
// - orientation code in status bits 2-1
// - facing in bit 0, one means back
// - bit 6 shows tilt lockout
// - status resets to front, portrait up, unlocked
// - hold result above 1.25 g on any axis
// - status keeps updating while flag set
// - clear mode bit: decrement or clear counter
// - detection runs only when enable bit set
// - eight-bit debounce count register, resets zero
// - wake/sleep change resets the debounce counter
// - time step follows sample period and mode
// - high resolution step stays 2.5 ms, except 1.25 ms at 800 Hz
// - three-bit tilt lock angle select, reset 29 deg
// - two-bit facing trip select, reset 75 deg
// - facing bounds from the trip select
`timescale 1ns/100ps
module od_detector #(
	parameter int STEP_UNIT_CYCLES = od_pkg::STEP_UNIT_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic signed [11:0] accX,
	input wire logic signed [11:0] accY,
	input wire logic signed [11:0] accZ,
	input wire logic sampleValid,
	input wire logic activeMode,
	input wire logic wakeState,
	input wire logic [2:0] outputSampleRate,
	input wire logic [1:0] oversampleMode,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic orientationIrq
);
	// ---------------------------------------------------------------
	// step multiplier in units of the smallest time step
	// ---------------------------------------------------------------
	function automatic logic [7:0] stepMult(input logic [2:0] rate, input logic [1:0] mode);
		if (rate == od_pkg::RATE_800)
			stepMult = 8'h01;
		else if (rate == od_pkg::RATE_400 || mode == od_pkg::MODE_HIGH_RES)
			stepMult = od_pkg::MULT_2_5MS;
		else if (rate < od_pkg::RATE_12_5)
			stepMult = 8'(8'h01 << rate); // 5, 10, 20 ms
		else if (mode == od_pkg::MODE_NORMAL)
			stepMult = 8'h10; // capped at 20 ms
		else if (mode == od_pkg::MODE_LOW_NOISE_LP || rate == od_pkg::RATE_12_5)
			stepMult = 8'h40; // 80 ms
		else
			stepMult = 8'h80; // 160 ms
	endfunction : stepMult

	function automatic logic isAddr(input logic [7:0] a, input logic [7:0] b);
		isAddr = (a == b);
	endfunction : isAddr

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic clearMode_q, clearMode_d, enable_q, enable_d;
	logic [7:0] dbCount_q, dbCount_d;
	logic [1:0] tripSel_q, tripSel_d;
	logic [2:0] lockSel_q, lockSel_d;
	logic [7:0] rdData_q, rdData_d;
	logic statusRead;

	// host writes; status is read-only
	always_comb begin
		clearMode_d = clearMode_q;
		enable_d = enable_q;
		dbCount_d = dbCount_q;
		tripSel_d = tripSel_q;
		lockSel_d = lockSel_q;
		if (regWrEn && isAddr(regAddr, od_pkg::ADDR_CONFIG)) begin
			clearMode_d = regWrData[od_pkg::CFG_CLEAR_MODE_BIT];
			enable_d = regWrData[od_pkg::CFG_ENABLE_BIT];
		end
		if (regWrEn && isAddr(regAddr, od_pkg::ADDR_DBCOUNT))
			dbCount_d = regWrData;
		if (regWrEn && isAddr(regAddr, od_pkg::ADDR_FACELOCK)) begin
			tripSel_d = regWrData[od_pkg::FL_TRIP_LSB +: 2];
			lockSel_d = regWrData[od_pkg::FL_LOCK_LSB +: 3];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			clearMode_q <= od_pkg::RST_CLEAR_MODE;
			enable_q <= od_pkg::RST_ENABLE;
			dbCount_q <= od_pkg::RST_DBCOUNT;
			tripSel_q <= od_pkg::RST_TRIP_SEL;
			lockSel_q <= od_pkg::RST_LOCK_SEL;
		end else begin
			clearMode_q <= clearMode_d;
			enable_q <= enable_d;
			dbCount_q <= dbCount_d;
			tripSel_q <= tripSel_d;
			lockSel_q <= lockSel_d;
		end
	end

	// ---------------------------------------------------------------
	// classifier
	// ---------------------------------------------------------------
	logic facing_q, facing_d, lock_q, lock_d, flag_q, flag_d, irq_q;
	logic [1:0] code_q, code_d;
	logic candFacing, candLock, candValid;
	logic [1:0] candCode;

	od_classifier classify (
		.clock(clock),
		.nrst(nrst),
		.accX(accX),
		.accY(accY),
		.accZ(accZ),
		.sampleValid(sampleValid),
		.tripSel(tripSel_q),
		.lockSel(lockSel_q),
		.curFacing(facing_q),
		.candFacing(candFacing),
		.candCode(candCode),
		.candLock(candLock),
		.candValid(candValid)
	);

	// ---------------------------------------------------------------
	// time step divider
	// ---------------------------------------------------------------
	logic [19:0] unitCnt_q, unitCnt_d;
	logic [7:0] multCnt_q, multCnt_d, mult;
	logic stepTick_q, stepTick_d, running;

	// one unit is the 800 Hz period; the step is a whole number of units
	always_comb begin
		running = enable_q && activeMode;
		mult = stepMult(outputSampleRate, oversampleMode);
		unitCnt_d = unitCnt_q + 20'h00001;
		multCnt_d = multCnt_q;
		stepTick_d = 1'b0;
		if (!running) begin
			unitCnt_d = 20'h00000;
			multCnt_d = 8'h00;
		end else if (unitCnt_q >= 20'(STEP_UNIT_CYCLES - 1)) begin
			unitCnt_d = 20'h00000;
			if (multCnt_q >= mult - 8'h01) begin
				multCnt_d = 8'h00;
				stepTick_d = 1'b1;
			end else begin
				multCnt_d = multCnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			unitCnt_q <= 20'h00000;
			multCnt_q <= 8'h00;
			stepTick_q <= 1'b0;
		end else begin
			unitCnt_q <= unitCnt_d;
			multCnt_q <= multCnt_d;
			stepTick_q <= stepTick_d;
		end
	end

	// ---------------------------------------------------------------
	// debounce and reported status
	// ---------------------------------------------------------------
	logic [7:0] dbc_q, dbc_d;
	logic first_q, first_d, active_q, wake_q, differs, report, setFlag;

	// a standby-to-active edge arms the first report; wake/sleep edges restart counting
	always_comb begin
		dbc_d = dbc_q;
		first_d = first_q;
		facing_d = facing_q;
		code_d = code_q;
		lock_d = lock_q;
		report = 1'b0;
		differs = (candFacing != facing_q) || (candCode != code_q) || (candLock != lock_q);
		if (activeMode && !active_q)
			first_d = 1'b1;
		if (wakeState != wake_q) begin
			dbc_d = 8'h00;
		end else if (stepTick_q && enable_q && candValid) begin
			if (first_q) begin
				report = 1'b1;
				first_d = 1'b0;
				dbc_d = 8'h00;
			end else if (differs) begin
				if (dbc_q >= dbCount_q) begin
					report = 1'b1;
					dbc_d = 8'h00;
				end else begin
					dbc_d = dbc_q + 8'h01;
				end
			end else if (clearMode_q) begin
				dbc_d = 8'h00;
			end else if (dbc_q != 8'h00) begin
				dbc_d = dbc_q - 8'h01;
			end
		end
		// results keep moving even while the flag is still set
		if (report) begin
			facing_d = candFacing;
			code_d = candCode;
			lock_d = candLock;
		end
		setFlag = report && (first_q || differs);
		statusRead = regRdEn && isAddr(regAddr, od_pkg::ADDR_STATUS);
		// a new event in the read cycle survives the clear
		flag_d = setFlag ? 1'b1 : (statusRead ? 1'b0 : flag_q);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dbc_q <= 8'h00;
			first_q <= 1'b0;
			active_q <= 1'b0;
			wake_q <= 1'b1; // awake idle level, so reset makes no false wake/sleep edge
			facing_q <= od_pkg::RST_FACING;
			code_q <= od_pkg::RST_CODE;
			lock_q <= od_pkg::RST_LOCK;
			flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			dbc_q <= dbc_d;
			first_q <= first_d;
			active_q <= activeMode;
			wake_q <= wakeState;
			facing_q <= facing_d;
			code_q <= code_d;
			lock_q <= lock_d;
			flag_q <= flag_d;
			irq_q <= flag_d;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	// unmapped offsets read zero; spare status and config bits read zero
	always_comb begin
		rdData_d = rdData_q;
		if (regRdEn) begin
			rdData_d = 8'h00;
			case (regAddr)
				od_pkg::ADDR_STATUS: begin
					rdData_d[od_pkg::STAT_CHANGE_BIT] = flag_q;
					rdData_d[od_pkg::STAT_LOCK_BIT] = lock_q;
					rdData_d[od_pkg::STAT_CODE_LSB +: 2] = code_q;
					rdData_d[od_pkg::STAT_FACING_BIT] = facing_q;
				end
				od_pkg::ADDR_CONFIG: begin
					rdData_d[od_pkg::CFG_CLEAR_MODE_BIT] = clearMode_q;
					rdData_d[od_pkg::CFG_ENABLE_BIT] = enable_q;
				end
				od_pkg::ADDR_DBCOUNT: rdData_d = dbCount_q;
				od_pkg::ADDR_FACELOCK: begin
					rdData_d[od_pkg::FL_TRIP_LSB +: 2] = tripSel_q;
					rdData_d[od_pkg::FL_FIXED_BIT] = 1'b1;
					rdData_d[od_pkg::FL_LOCK_LSB +: 3] = lockSel_q;
				end
				default: rdData_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			rdData_q <= 8'h00;
		else
			rdData_q <= rdData_d;
	end

	assign regRdData = rdData_q;
	assign orientationIrq = irq_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_change_sets_flag: assert property (
		(facing_q != $past(facing_q) || code_q != $past(code_q) || lock_q != $past(lock_q)) |-> flag_q)
		else $error("status changed without change flag");
	chk_read_clears_flag: assert property (
		(statusRead && !setFlag) |=> !flag_q)
		else $error("status read left change flag set");
	chk_irq_tracks_flag: assert property (
		orientationIrq == flag_q)
		else $error("interrupt differs from change flag");
	chk_status_layout: assert property (
		statusRead |=> regRdData == {$past(flag_q), $past(lock_q), 3'h0, $past(code_q), $past(facing_q)})
		else $error("status read data layout wrong");
	chk_clear_mode_zero: assert property (
		(stepTick_q && enable_q && candValid && !first_q && !differs && clearMode_q && wakeState == wake_q)
		|=> dbc_q == 8'h00)
		else $error("clear mode did not clear counter");
	chk_decrement_mode: assert property (
		(stepTick_q && enable_q && candValid && !first_q && !differs && !clearMode_q
		&& dbc_q != 8'h00 && wakeState == wake_q) |=> dbc_q == $past(dbc_q) - 8'h01)
		else $error("decrement mode did not decrement");
	chk_wake_resets: assert property (
		(wakeState != wake_q) |=> dbc_q == 8'h00)
		else $error("wake change kept debounce count");
	chk_disabled_frozen: assert property (
		(!enable_q && !statusRead) |=> $stable(flag_q) && $stable(code_q) && $stable(facing_q) && $stable(lock_q))
		else $error("disabled detector changed status");
	chk_high_resolution_mode_step: assert property (
		(oversampleMode == od_pkg::MODE_HIGH_RES && outputSampleRate != od_pkg::RATE_800)
		|-> mult == od_pkg::MULT_2_5MS)
		else $error("high resolution step not 2.5 ms");
endmodule : od_detector

// >>> rtl/od_pkg.sv
// shared constants of the orientation detector
package od_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CONFIG = 8'h11;
	localparam logic [7:0] ADDR_DBCOUNT = 8'h12;
	localparam logic [7:0] ADDR_FACELOCK = 8'h13;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int STAT_CHANGE_BIT = 7;
	localparam int STAT_LOCK_BIT = 6;
	localparam int STAT_CODE_LSB = 1;
	localparam int STAT_FACING_BIT = 0;
	localparam int CFG_CLEAR_MODE_BIT = 7;
	localparam int CFG_ENABLE_BIT = 6;
	localparam int FL_TRIP_LSB = 6;
	localparam int FL_FIXED_BIT = 3;
	localparam int FL_LOCK_LSB = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic RST_CLEAR_MODE = 1'b1;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [7:0] RST_DBCOUNT = 8'h00;
	localparam logic [1:0] RST_TRIP_SEL = 2'h1;
	localparam logic [2:0] RST_LOCK_SEL = 3'h4;
	localparam logic [1:0] RST_CODE = 2'h0;
	localparam logic RST_FACING = 1'b0;
	localparam logic RST_LOCK = 1'b0;

	// ---------------------------------------------------------------
	// orientation codes and oversampling modes
	// ---------------------------------------------------------------
	localparam logic [1:0] CODE_PORTRAIT_UP = 2'h0;
	localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
	localparam logic [1:0] CODE_LANDSCAPE_RIGHT = 2'h2;
	localparam logic [1:0] CODE_LANDSCAPE_LEFT = 2'h3;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_LOW_NOISE_LP = 2'h1;
	localparam logic [1:0] MODE_HIGH_RES = 2'h2;
	localparam logic [1:0] MODE_LOW_POWER = 2'h3;

	// ---------------------------------------------------------------
	// acceleration thresholds, counts at 1024 per g
	// ---------------------------------------------------------------
	localparam logic [11:0] OVER_RANGE_LIMIT = 12'h500;
	localparam logic [11:0] FACING_TRIP_80 = 12'h0B2;
	localparam logic [11:0] FACING_TRIP_75 = 12'h109;
	localparam logic [11:0] FACING_TRIP_70 = 12'h15E;
	localparam logic [11:0] FACING_TRIP_65 = 12'h1B1;
	localparam logic [11:0] LOCK_14 = 12'h3E2;
	localparam logic [11:0] LOCK_18 = 12'h3CE;
	localparam logic [11:0] LOCK_21 = 12'h3BC;
	localparam logic [11:0] LOCK_25 = 12'h3A0;
	localparam logic [11:0] LOCK_29 = 12'h380;
	localparam logic [11:0] LOCK_33 = 12'h35B;
	localparam logic [11:0] LOCK_37 = 12'h332;
	localparam logic [11:0] LOCK_42 = 12'h2F9;

	// ---------------------------------------------------------------
	// timing: smallest time step and its cycle count
	// ---------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int STEP_UNIT_NS = 1250000;
	localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLOCK_PERIOD_NS;
	localparam logic [2:0] RATE_800 = 3'h0;
	localparam logic [2:0] RATE_400 = 3'h1;
	localparam logic [2:0] RATE_12_5 = 3'h5;
	localparam logic [7:0] MULT_2_5MS = 8'h02;
endpackage : od_pkg

// >>> tb/od_host_model.sv
// host side model that drives the detector's register port
`timescale 1ns/100ps
module od_host_model (
	input wire logic clock,
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	output logic regRdEn,
	input wire logic [7:0] regRdData
);
	// idle bus shows inverted address and data so no stale value looks valid
	initial begin
		regAddr = 8'hFF;
		regWrEn = 1'b0;
		regWrData = 8'hFF;
		regRdEn = 1'b0;
	end

	// ---------------------------------------------------------------
	// register access, driven on the falling edge
	// ---------------------------------------------------------------
	// one-cycle write strobe, then the bus goes idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clock);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask : wr

	// data is taken a full cycle after the strobe, it stands until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clock);
		regRdEn = 1'b0;
		regAddr = ~a;
		@(negedge clock);
		d = regRdData;
	endtask : rd
endmodule : od_host_model

// >>> tb/tb_top.sv
// self-checking bench for the orientation detector
`timescale 1ns/100ps
module tb_top;
	// ---------------------------------------------------------------
	// signals and tables
	// ---------------------------------------------------------------
	// short time unit: the slowest step is then 512 cycles
	localparam int STEP = 4;
	logic clock;
	logic nrst;
	logic signed [11:0] accX;
	logic signed [11:0] accY;
	logic signed [11:0] accZ;
	logic sampleValid;
	logic activeMode;
	logic wakeState;
	logic [2:0] outputSampleRate;
	logic [1:0] oversampleMode;
	logic [7:0] regAddr;
	logic regWrEn;
	logic [7:0] regWrData;
	logic regRdEn;
	logic [7:0] regRdData;
	logic orientationIrq;
	logic [7:0] rdv;
	int numErrors;
	int samplesChecked;
	// poses: up/front, down/back, right/front, left/back, tilted lock, over range, shallow front
	logic [11:0] px [7] = '{12'h000, 12'h000, 12'h300, 12'hD00, 12'h000, 12'h600, 12'h000};
	logic [11:0] py [7] = '{12'h300, 12'hD00, 12'h000, 12'h000, 12'h100, 12'h000, 12'h300};
	logic [11:0] pz [7] = '{12'hE00, 12'h200, 12'hE00, 12'h200, 12'h3C0, 12'h000, 12'hF38};
	logic [7:0] pe [7] = '{8'h80, 8'h83, 8'h84, 8'h87, 8'hC1, 8'h00, 8'h80};
	logic [7:0] ra [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
	logic [7:0] wv [4] = '{8'hFF, 8'h00, 8'hA5, 8'hC3};
	logic [7:0] rv [2][5] = '{'{8'h00, 8'h80, 8'h00, 8'h4C, 8'h00}, '{8'h00, 8'h00, 8'hA5, 8'hCB, 8'h00}};
	// rate, mode and step multiple, in rising step length
	logic [2:0] tr [10] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2, 3'h4, 3'h7, 3'h5, 3'h5, 3'h6};
	logic [1:0] tm [10] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1, 2'h3, 2'h3};
	int tu [10] = '{1, 2, 2, 2, 4, 16, 16, 64, 64, 128};

	// design and host model
	od_detector #(.STEP_UNIT_CYCLES(STEP)) od_detector_i (
		.clock(clock), .nrst(nrst), .accX(accX), .accY(accY), .accZ(accZ),
		.sampleValid(sampleValid), .activeMode(activeMode), .wakeState(wakeState),
		.outputSampleRate(outputSampleRate), .oversampleMode(oversampleMode),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .orientationIrq(orientationIrq)
	);
	od_host_model od_host_model_i (
		.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdEn(regRdEn), .regRdData(regRdData)
	);

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic finishTest;
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finishTest

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one-cycle sample pulse of a pose
	task automatic smp(input int i);
		@(negedge clock);
		accX = px[i];
		accY = py[i];
		accZ = pz[i];
		sampleValid = 1'b1;
		@(negedge clock);
		sampleValid = 1'b0;
	endtask : smp

	// the interrupt must stay low for n cycles
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clock);
			seen = seen | orientationIrq;
		end
		check({7'h00, seen}, 8'h00);
	endtask : quiet

	task automatic stat(input logic [7:0] e);
		od_host_model_i.rd(od_pkg::ADDR_STATUS, rdv);
		check(rdv, e);
	endtask : stat

	// bounded wait for the interrupt, then read status and see the line drop
	task automatic report(input logic [7:0] e, input int lim = 1200);
		int i;
		i = 0;
		while (orientationIrq !== 1'b1 && i < lim) begin
			@(negedge clock);
			i++;
		end
		if (orientationIrq !== 1'b1) begin
			check({7'h00, orientationIrq}, 8'h01);
			finishTest();
		end else begin
			stat(e);
			check({7'h00, orientationIrq}, 8'h00);
		end
	endtask : report

	// new pose, brief return to the reported one, new pose again
	task automatic bounce(input int a, input int b, input logic fire);
		smp(a);
		repeat (30) @(negedge clock);
		smp(b);
		repeat (6) @(negedge clock);
		smp(a);
		repeat (22) @(negedge clock);
		check({7'h00, orientationIrq}, {7'h00, fire});
	endtask : bounce

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		accX = 12'h000;
		accY = 12'h000;
		accZ = 12'h000;
		sampleValid = 1'b0;
		activeMode = 1'b0;
		wakeState = 1'b1;
		outputSampleRate = 3'h0;
		oversampleMode = 2'h0;
		numErrors = 0;
		samplesChecked = 0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		nrst = 1'b1;
		// reset values, then access kinds: status ignores writes, unmapped reads zero
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 5; i++) begin
				od_host_model_i.rd(ra[i], rdv);
				check(rdv, rv[j][i]);
			end
			for (int i = 0; i < 4; i++) od_host_model_i.wr(ra[i], wv[i]);
		end
		od_host_model_i.wr(od_pkg::ADDR_CONFIG, 8'h80);
		od_host_model_i.wr(od_pkg::ADDR_DBCOUNT, 8'h00);
		od_host_model_i.wr(od_pkg::ADDR_FACELOCK, 8'h4C);
		// active but disabled: nothing reported
		activeMode = 1'b1;
		smp(1);
		quiet(40);
		stat(8'h00);
		// first result after enabling flags even the default pose
		smp(0);
		od_host_model_i.wr(od_pkg::ADDR_CONFIG, 8'hC0);
		report(pe[0]);
		stat(8'h00);
		for (int i = 1; i < 5; i++) begin
			smp(i);
			report(pe[i]);
		end
		// second change while the flag is still set
		smp(2);
		report(pe[2]);
		smp(0);
		repeat (20) @(negedge clock);
		check({7'h00, orientationIrq}, 8'h01);
		smp(3);
		repeat (20) @(negedge clock);
		stat(8'h87);
		// over-range sample holds the result
		smp(5);
		quiet(40);
		stat(8'h07);
		// standby and back arms a fresh first result
		activeMode = 1'b0;
		repeat (3) @(negedge clock);
		activeMode = 1'b1;
		smp(3);
		report(8'h87);
		// debounce of ten steps: clear mode resets, decrement mode keeps progress
		od_host_model_i.wr(od_pkg::ADDR_DBCOUNT, 8'h09);
		bounce(0, 3, 1'b0);
		report(8'h80);
		od_host_model_i.wr(od_pkg::ADDR_CONFIG, 8'h40);
		bounce(3, 0, 1'b1);
		stat(8'h87);
		// wake/sleep change in mid-count restarts the count
		smp(0);
		repeat (30) @(negedge clock);
		wakeState = 1'b0;
		repeat (24) @(negedge clock);
		check({7'h00, orientationIrq}, 8'h00);
		report(8'h80);
		// shallowest lock angle and steepest facing trip move both verdicts
		od_host_model_i.wr(od_pkg::ADDR_FACELOCK, 8'h00);
		smp(4);
		report(8'h81);
		smp(6);
		report(pe[6]);
		od_host_model_i.wr(od_pkg::ADDR_FACELOCK, 8'h4C);
		// step length for ten rate and mode pairs, two steps of debounce
		od_host_model_i.wr(od_pkg::ADDR_CONFIG, 8'hC0);
		od_host_model_i.wr(od_pkg::ADDR_DBCOUNT, 8'h01);
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			outputSampleRate = tr[i];
			oversampleMode = tm[i];
			smp((i % 2 == 0) ? 3 : 0);
			quiet(STEP * tu[i] - 2);
			// the second step must land within one more step length plus 8 cycles
			report(pe[(i % 2 == 0) ? 3 : 0], STEP * tu[i] + 8);
		end
		finishTest();
	end
endmodule : tb_top
